// >>> hw/spc_ctrl.sv
`timescale 1ns/1ns
module spc_ctrl (
	input  wire logic        MCLK_I,
	input  wire logic        RESET_N_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic [31:0]      PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic        SCL_I,
	input  wire logic        SDA_I,
	input  wire logic        SCL_GPIO_O_I,
	input  wire logic        SCL_GPIO_OE_I,
	input  wire logic        SDA_GPIO_O_I,
	input  wire logic        SDA_GPIO_OE_I,
	input  wire logic        RX_BYTE_I,
	input  wire logic [7:0]  RX_DATA_I,
	input  wire logic        TX_BUSY_I,
	output logic             SCL_O,
	output logic             SCL_OE_O,
	output logic             SDA_O,
	output logic             SDA_OE_O,
	output logic [7:0]       TX_DATA_O,
	output logic             SLAVE_EN_O,
	output logic             ADDR10_O,
	output logic             IRQ_O
);
	// ************************************************************
	// mode decode
	// ************************************************************
	typedef enum {SPC_BUS_OFF, SPC_BUS_SLAVE, SPC_BUS_FWM} spc_bus_e;

	function automatic spc_bus_e spc_decode(input logic [3:0] m);
		case (m)
			spc_pkg::MODE_S7, spc_pkg::MODE_S10,
			spc_pkg::MODE_S7I, spc_pkg::MODE_S10I: spc_decode = SPC_BUS_SLAVE;
			spc_pkg::MODE_FWM: spc_decode = SPC_BUS_FWM;
			default: spc_decode = SPC_BUS_OFF;
		endcase
	endfunction

	logic [7:0]  ctrl_q;
	logic [7:0]  sadr_q;
	logic [7:0]  amsk_q;
	logic [7:0]  rxbuf_q;
	logic        full_q;
	logic [spc_pkg::IRQ_W-1:0] irq_st_q;
	logic [spc_pkg::IRQ_W-1:0] irq_msk_q;
	logic [spc_pkg::IRQ_W-1:0] ev;
	logic        scl_s;
	logic        sda_s;
	logic        scl_p_q;
	logic        sda_p_q;
	logic        hold_q;
	logic        wr;
	logic        rd;
	logic        en;
	logic [3:0]  mode;
	spc_bus_e    bus;
	logic        start_ev;
	logic        stop_ev;
	logic        write_collision_flag_ev;
	logic        ovf_ev;
	logic        ctrl_wr;
	logic        buf_wr;
	logic        buf_rd;
	logic        mask_sel;

	spc_sync u_scl (
		.clk_i   (MCLK_I),
		.rst_n_i (RESET_N_I),
		.d_i     (SCL_I),
		.q_o     (scl_s)
	);
	spc_sync u_sda (
		.clk_i   (MCLK_I),
		.rst_n_i (RESET_N_I),
		.d_i     (SDA_I),
		.q_o     (sda_s)
	);

	// ************************************************************
	// bus access
	// ************************************************************
	// zero wait state: pready always high once out of reset
	assign wr   = PSEL_I & PENABLE_I & PWRITE_I;
	assign rd   = PSEL_I & PENABLE_I & ~PWRITE_I;
	assign en   = ctrl_q[spc_pkg::BIT_EN];
	assign mode = ctrl_q[3:0];
	assign bus  = en ? spc_decode(mode) : SPC_BUS_OFF;
	assign mask_sel = (mode == spc_pkg::MODE_MSKLD);
	assign ctrl_wr  = wr && PADDR_I == spc_pkg::ADDR_CTRL;
	assign buf_wr   = wr && PADDR_I == spc_pkg::ADDR_BUF;
	assign buf_rd   = rd && PADDR_I == spc_pkg::ADDR_BUF;

	assign write_collision_flag_ev  = buf_wr & TX_BUSY_I;
	assign ovf_ev   = RX_BYTE_I & full_q & (bus == SPC_BUS_SLAVE);
	assign start_ev = (bus != SPC_BUS_OFF) & scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_ev  = (bus != SPC_BUS_OFF) & scl_s & scl_p_q & ~sda_p_q & sda_s;

	always_comb begin
		ev = '0;
		ev[spc_pkg::IRQ_BYTE] = RX_BYTE_I & (bus == SPC_BUS_SLAVE) & ~full_q;
		ev[spc_pkg::IRQ_START] = start_ev & (mode[3] | mode == spc_pkg::MODE_FWM) & mode[1];
		ev[spc_pkg::IRQ_STOP]  = stop_ev & (mode[3] | mode == spc_pkg::MODE_FWM) & mode[1];
		ev[spc_pkg::IRQ_WRITE_COLLISION_FLAG]  = write_collision_flag_ev;
		ev[spc_pkg::IRQ_OVF]   = ovf_ev;
	end

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// control register; hardware flag set beats software clear
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ctrl_q <= spc_pkg::CTRL_RST;
		end else begin
			if (ctrl_wr) begin
				ctrl_q <= PWDATA_I[7:0];
			end
			if (write_collision_flag_ev) begin
				ctrl_q[spc_pkg::BIT_WRITE_COLLISION_FLAG] <= 1'b1;
			end
			if (ovf_ev) begin
				ctrl_q[spc_pkg::BIT_OVF] <= 1'b1;
			end
		end
	end

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			sadr_q <= spc_pkg::ADR_RST;
			amsk_q <= spc_pkg::MASK_RST;
		end else if (wr && PADDR_I == spc_pkg::ADDR_SLVADR) begin
			if (mask_sel) begin
				amsk_q <= PWDATA_I[7:0];
			end else begin
				sadr_q <= PWDATA_I[7:0];
			end
		end
	end

	// receive holding buffer
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rxbuf_q <= 8'h00;
			full_q  <= 1'b0;
		end else if (RX_BYTE_I && bus == SPC_BUS_SLAVE && !full_q) begin
			rxbuf_q <= RX_DATA_I;
			full_q  <= 1'b1;
		end else if (buf_rd) begin
			full_q  <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			TX_DATA_O <= 8'h00;
		end else if (buf_wr && !TX_BUSY_I) begin
			TX_DATA_O <= PWDATA_I[7:0];
		end
	end

	// ************************************************************
	// interrupts
	// ************************************************************
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			irq_st_q  <= '0;
			irq_msk_q <= '0;
			IRQ_O     <= 1'b0;
		end else begin
			if (wr && PADDR_I == spc_pkg::ADDR_IRQST) begin
				irq_st_q <= (irq_st_q & ~PWDATA_I[spc_pkg::IRQ_W-1:0]) | ev;
			end else begin
				irq_st_q <= irq_st_q | ev;
			end
			if (wr && PADDR_I == spc_pkg::ADDR_IRQMSK) begin
				irq_msk_q <= PWDATA_I[spc_pkg::IRQ_W-1:0];
			end
			IRQ_O <= |(irq_st_q & irq_msk_q);
		end
	end

	// ************************************************************
	// read path
	// ************************************************************
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			PRDATA_O  <= 32'h0000_0000;
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O  <= 1'b1;
			PSLVERR_O <= 1'b0;
			PRDATA_O  <= 32'h0000_0000;
			if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
				case (PADDR_I)
					spc_pkg::ADDR_CTRL:   PRDATA_O[7:0] <= ctrl_q;
					spc_pkg::ADDR_SLVADR: PRDATA_O[7:0] <= mask_sel ? amsk_q : sadr_q;
					spc_pkg::ADDR_BUF:    PRDATA_O[7:0] <= rxbuf_q;
					spc_pkg::ADDR_STAT:   PRDATA_O[2:0] <= {scl_s, sda_s, full_q};
					spc_pkg::ADDR_IRQST:  PRDATA_O[spc_pkg::IRQ_W-1:0] <= irq_st_q;
					spc_pkg::ADDR_IRQMSK: PRDATA_O[spc_pkg::IRQ_W-1:0] <= irq_msk_q;
					default:              PRDATA_O <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ************************************************************
	// clock stretch and pin ownership
	// ************************************************************
	// hold only after low
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			hold_q <= 1'b0;
		end else if (bus != SPC_BUS_SLAVE || ctrl_q[spc_pkg::BIT_REL]) begin
			hold_q <= 1'b0;
		end else if (!scl_s) begin
			hold_q <= 1'b1;
		end
	end

	// open drain while enabled: output level low, enable does the work; GPIO inputs drive the pins when disabled
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			SCL_O      <= 1'b0;
			SCL_OE_O   <= 1'b0;
			SDA_O      <= 1'b0;
			SDA_OE_O   <= 1'b0;
			SLAVE_EN_O <= 1'b0;
			ADDR10_O   <= 1'b0;
		end else begin
			if (en) begin
				SCL_O    <= 1'b0;
				SDA_O    <= 1'b0;
				SCL_OE_O <= hold_q;
				SDA_OE_O <= 1'b0;
			end else begin
				SCL_O    <= SCL_GPIO_O_I;
				SCL_OE_O <= SCL_GPIO_OE_I;
				SDA_O    <= SDA_GPIO_O_I;
				SDA_OE_O <= SDA_GPIO_OE_I;
			end
			SLAVE_EN_O <= (bus == SPC_BUS_SLAVE);
			ADDR10_O   <= (bus == SPC_BUS_SLAVE) & mode[0];
		end
	end
endmodule // spc_ctrl

// >>> hw/spc_pkg.sv
package spc_pkg;
	// ************************************************************
	// register byte addresses
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_SLVADR = 8'h04;
	localparam logic [7:0] ADDR_BUF    = 8'h08;
	localparam logic [7:0] ADDR_STAT   = 8'h0c;
	localparam logic [7:0] ADDR_IRQST  = 8'h10;
	localparam logic [7:0] ADDR_IRQMSK = 8'h14;

	// ************************************************************
	// control fields and reset values
	// ************************************************************
	localparam int          BIT_WRITE_COLLISION_FLAG  = 7;
	localparam int          BIT_OVF   = 6;
	localparam int          BIT_EN    = 5;
	localparam int          BIT_REL   = 4;
	localparam logic [7:0]  CTRL_RST  = 8'h00;
	localparam logic [7:0]  MASK_RST  = 8'hff;
	localparam logic [7:0]  ADR_RST   = 8'h00;

	localparam logic [3:0] MODE_S7    = 4'h6;
	localparam logic [3:0] MODE_S10   = 4'h7;
	localparam logic [3:0] MODE_MSKLD = 4'h9;
	localparam logic [3:0] MODE_FWM   = 4'hb;
	localparam logic [3:0] MODE_S7I   = 4'he;
	localparam logic [3:0] MODE_S10I  = 4'hf;

	// interrupt status bits
	localparam int IRQ_BYTE  = 0;
	localparam int IRQ_START = 1;
	localparam int IRQ_STOP  = 2;
	localparam int IRQ_WRITE_COLLISION_FLAG  = 3;
	localparam int IRQ_OVF   = 4;
	localparam int IRQ_W     = 5;
endpackage

// >>> hw/spc_sync.sv
`timescale 1ns/1ns
// ************************************************************
// two flop synchroniser for pin inputs
// ************************************************************
module spc_sync (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic meta_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= 1'b1;
			q_o    <= 1'b1;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule // spc_sync

// >>> dv/spc_ctrl_assertions.sv
`timescale 1ns/1ns
module spc_ctrl_assertions (
	input wire logic        MCLK_I,
	input wire logic        RESET_N_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [7:0]  PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic        TX_BUSY_I,
	input wire logic        SCL_I,
	input wire logic        SCL_O,
	input wire logic        SCL_OE_O,
	input wire logic [7:0]  TX_DATA_O,
	input wire logic        SLAVE_EN_O,
	input wire logic        ADDR10_O
);
	// ************************************************************
	// checks at the ports
	// ************************************************************
	logic wr_c;
	logic wr_b;
	assign wr_c = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == spc_pkg::ADDR_CTRL;
	assign wr_b = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == spc_pkg::ADDR_BUF;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RESET_N_I);
	chk_stretch_low: assert property (SLAVE_EN_O && SCL_OE_O |-> !SCL_O)
		else $error("stretch drives high");
	chk_hold_after_low: assert property (SLAVE_EN_O && $rose(SCL_OE_O) |-> !$past(SCL_I, 2))
		else $error("clock held before seen low");
	chk_release_frees: assert property (wr_c && PWDATA_I[5:4] == 2'b11 && PWDATA_I[2:1] == 2'b11
		|-> ##3 !SCL_OE_O)
		else $error("clock not released");
	chk_mode_slave: assert property (wr_c |-> ##2
		SLAVE_EN_O == ($past(PWDATA_I[5], 2) && $past(PWDATA_I[2:1], 2) == 2'b11))
		else $error("slave enable wrong for mode");
	chk_mode_addr10: assert property (wr_c |-> ##2
		ADDR10_O == ($past(PWDATA_I[5], 2) && $past(PWDATA_I[2:0], 2) == 3'b111))
		else $error("ten bit flag wrong for mode");
	chk_buf_load: assert property (wr_b && !TX_BUSY_I |-> ##2 TX_DATA_O == $past(PWDATA_I[7:0], 2))
		else $error("buffer word not loaded");
	chk_write_collision_flag_drop: assert property (wr_b && TX_BUSY_I |=> $stable(TX_DATA_O) [*2])
		else $error("colliding write not dropped");
	// 8-bit registers, upper bits zero
	chk_read_width: assert property (PRDATA_O[31:8] == 24'h0)
		else $error("upper read bits set");
endmodule // spc_ctrl_assertions

bind spc_ctrl spc_ctrl_assertions i_spc_ctrl_assertions (
	.MCLK_I     (MCLK_I),
	.RESET_N_I  (RESET_N_I),
	.PSEL_I     (PSEL_I),
	.PENABLE_I  (PENABLE_I),
	.PWRITE_I   (PWRITE_I),
	.PADDR_I    (PADDR_I),
	.PWDATA_I   (PWDATA_I),
	.PRDATA_O   (PRDATA_O),
	.TX_BUSY_I  (TX_BUSY_I),
	.SCL_I      (SCL_I),
	.SCL_O      (SCL_O),
	.SCL_OE_O   (SCL_OE_O),
	.TX_DATA_O  (TX_DATA_O),
	.SLAVE_EN_O (SLAVE_EN_O),
	.ADDR10_O   (ADDR10_O)
);

// >>> dv/spc_i2c_master.sv
`timescale 1ns/1ns
module spc_i2c_master (
	input  wire logic go_i,
	input  wire logic scl_oe_i,
	input  wire logic scl_i,
	input  wire logic sda_oe_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o,
	output logic      done_o
);
	logic m_scl = 1'b1;
	logic m_sda = 1'b1;
	initial done_o = 1'b1;
	// pull-ups: a line is low while any party drives it low
	assign scl_o = m_scl & ~(scl_oe_i & ~scl_i);
	assign sda_o = m_sda & ~(sda_oe_i & ~sda_i);
	// clock only runs inside a frame, 80 ns period
	always @(posedge go_i) begin
		// keep pin changes off the core clock edge
		#1;
		done_o = 1'b0;
		m_sda = 1'b0;
		#40;
		for (int i = 0; i < 9; i++) begin
			m_scl = 1'b0;
			m_sda = i[0];
			#40;
			m_scl = 1'b1;
			wait (scl_o);
			#40;
		end
		m_scl = 1'b0;
		m_sda = 1'b0;
		#40;
		m_scl = 1'b1;
		#40;
		m_sda = 1'b1;
		done_o = 1'b1;
	end
endmodule // spc_i2c_master

// >>> dv/test_i2c_slave_port_control.sv
`timescale 1ns/1ns
module test_i2c_slave_port_control;
	logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic        rxb = 1'b0, txb = 1'b0, go = 1'b0, g_o = 1'b0, g_oe = 1'b0;
	logic [7:0]  paddr = 8'h00, rxd = 8'h00, txd;
	logic [31:0] pwd = 32'h0, prd, rv;
	logic        scl, sda, done, scl_o, scl_oe, sda_o, sda_oe, slv, a10, irq, rdy;
	int          num_errors = 0, tests_run = 0;
	always #2 mclk = ~mclk;
	spc_ctrl i_spc_ctrl (.MCLK_I(mclk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy),
		.PSLVERR_O(), .SCL_I(scl), .SDA_I(sda), .SCL_GPIO_O_I(g_o), .SCL_GPIO_OE_I(g_oe),
		.SDA_GPIO_O_I(g_o), .SDA_GPIO_OE_I(g_oe), .RX_BYTE_I(rxb), .RX_DATA_I(rxd),
		.TX_BUSY_I(txb), .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
		.TX_DATA_O(txd), .SLAVE_EN_O(slv), .ADDR10_O(a10), .IRQ_O(irq));
	spc_i2c_master i_spc_i2c_master (.go_i(go), .scl_oe_i(scl_oe), .scl_i(scl_o),
		.sda_oe_i(sda_oe), .sda_i(sda_o), .scl_o(scl), .sda_o(sda), .done_o(done));
	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge mclk);
		pen <= 1'b1;
		do @(posedge mclk); while (rdy !== 1'b1);
		rv = prd;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rv);
	endtask
	task automatic frame;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		for (int n = 0; n < 3000 && done !== 1'b1; n++) @(posedge mclk);
		// let the stop condition pass the pin synchroniser
		repeat (4) @(posedge mclk);
	endtask
	task automatic close_out;
		$display("errors %0d comparisons %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_regs;
		rdc("ctrl", 8'h00, 32'h0);
		rdc("unmapped", 8'h1c, 32'h0);
		apb(1'b1, 8'h00, 32'h39);
		rdc("mask", 8'h04, 32'hff);
		apb(1'b1, 8'h04, 32'h33);
		rdc("mask_w", 8'h04, 32'h33);
		apb(1'b1, 8'h00, 32'h36);
		rdc("adr", 8'h04, 32'h0);
	endtask
	task automatic t_gpio;
		apb(1'b1, 8'h00, 32'h0);
		g_oe <= 1'b1;
		g_o <= 1'b1;
		repeat (4) @(posedge mclk);
		chk("gpio_oe", 32'h1, scl_oe);
		chk("gpio_o", 32'h1, scl_o);
		chk("gpio_sda_oe", 32'h1, sda_oe);
		apb(1'b1, 8'h00, 32'h36);
		repeat (4) @(posedge mclk);
		chk("port_oe", 32'h0, scl_oe);
		g_oe <= 1'b0;
		g_o <= 1'b0;
	endtask
	task automatic t_modes;
		for (int m = 0; m < 16; m++) begin
			apb(1'b1, 8'h00, 32'h30 | m);
			repeat (3) @(posedge mclk);
			chk("slave", m[2:1] == 2'b11, slv);
			chk("addr10", m[2:0] == 3'b111, a10);
		end
	endtask
	task automatic t_frame(input logic [3:0] m, input logic [31:0] e);
		apb(1'b1, 8'h10, 32'hff);
		apb(1'b1, 8'h00, {28'h3, m});
		frame;
		chk("frame_done", 32'h1, done);
		rdc("start_stop", 8'h10, e);
	endtask
	task automatic t_stretch;
		apb(1'b1, 8'h10, 32'hff);
		apb(1'b1, 8'h14, 32'h02);
		apb(1'b1, 8'h00, 32'h2e);
		go <= 1'b1;
		repeat (5) @(posedge mclk);
		go <= 1'b0;
		chk("scl_high", 32'h1, scl);
		repeat (60) @(posedge mclk);
		chk("held_oe", 32'h1, scl_oe);
		chk("held_scl", 32'h0, scl);
		chk("irq_on", 32'h1, irq);
		apb(1'b1, 8'h10, 32'h2);
		repeat (2) @(posedge mclk);
		chk("irq_clr", 32'h0, irq);
		apb(1'b1, 8'h00, 32'h3e);
		for (int n = 0; n < 3000 && done !== 1'b1; n++) @(posedge mclk);
		chk("done", 32'h1, done);
		repeat (4) @(posedge mclk);
		chk("irq_mask", 32'h0, irq);
	endtask
	task automatic t_flags;
		apb(1'b1, 8'h00, 32'h36);
		apb(1'b1, 8'h10, 32'hff);
		rxd <= 8'ha5;
		rxb <= 1'b1;
		@(posedge mclk);
		rxb <= 1'b0;
		rdc("buf", 8'h08, 32'ha5);
		repeat (2) begin
			rxb <= 1'b1;
			@(posedge mclk);
			rxb <= 1'b0;
			@(posedge mclk);
		end
		rdc("ovf", 8'h00, 32'h76);
		txb <= 1'b1;
		apb(1'b1, 8'h08, 32'h11);
		rdc("write_collision_flag", 8'h00, 32'hf6);
		chk("tx_kept", 32'h0, txd);
		rdc("irq_st", 8'h10, 32'h19);
		txb <= 1'b0;
		apb(1'b1, 8'h08, 32'h5a);
		@(posedge mclk);
		chk("tx_load", 32'h5a, txd);
		apb(1'b1, 8'h00, 32'h36);
		rdc("cleared", 8'h00, 32'h36);
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		t_regs;
		t_gpio;
		t_modes;
		t_frame(4'he, 32'h6);
		t_frame(4'hb, 32'h6);
		t_frame(4'hf, 32'h6);
		t_frame(4'h6, 32'h0);
		t_frame(4'h8, 32'h0);
		t_stretch;
		t_flags;
		close_out;
	end
	initial begin
		#60000;
		num_errors++;
		close_out;
	end
endmodule // test_i2c_slave_port_control
